// >>> spi_eeprom_pin_interface.sv
`default_nettype none
// Overview of operation
// - Output bit shifts onto the serial output at each serial clock falling edge after the instruction byte.
// - Opcode, address and data bits captured on serial clock rising edges.
// - Select high deselects device and floats the serial output.
// - Deselect enters standby unless a nonvolatile write is still running.
// - Select low makes the device active and ready for operations.
// - After power-up operations wait for a select falling edge.
// - Write protect low blocks nonvolatile writes; reads still work.
// - Write protect high allows every function including writes.
// - Write protect falling during a selected write aborts that write.
// - A started nonvolatile cycle completes regardless of write protect.
// - All bytes shift most significant bit first in both directions.
// - An 8-bit instruction register loads serially at the start of each transfer.
// - A stopped serial clock keeps transfer state and resumes at the same bit.
module spi_eeprom_pin_interface
	import spi_pin_pkg::*;
#(
	parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic select_watchdog_in_n,
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic write_protect_n,
	output logic serial_out,
	output logic serial_out_oe,
	output logic standby,
	output logic nv_write_busy,
	output logic instr_valid,
	output logic [7:0] instr_q,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_first,
	input wire logic rx_ready,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	input wire logic tx_valid
);

	if (NV_CYCLES < 1) begin : g_bad_cycles
		$error("NV_CYCLES must be at least one");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic sck_prev_q;
	logic sel_prev_n_q;
	logic wp_prev_n_q;
	// Reset leaves select looking low, so a select held low through reset shows no falling
	// edge; only a genuine high-to-low transition can arm the device.
	localparam logic [3:0] PIN_RST = 4'h1;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			meta_q <= PIN_RST;
			sync_q <= PIN_RST;
			sck_prev_q <= 1'b0;
			sel_prev_n_q <= 1'b0;
			wp_prev_n_q <= 1'b1;
		end else if (clk_en) begin
			meta_q <= {select_watchdog_in_n, serial_clk, serial_in, write_protect_n};
			sync_q <= meta_q;
			sck_prev_q <= sync_q[2];
			sel_prev_n_q <= sync_q[3];
			wp_prev_n_q <= sync_q[0];
		end
	end

	logic sel_n;
	logic sck_rise;
	logic sck_fall;
	logic sel_fall;
	logic wp_fall;
	assign sel_n = sync_q[3];
	assign sck_rise = sync_q[2] && !sck_prev_q;
	assign sck_fall = !sync_q[2] && sck_prev_q;
	assign sel_fall = !sel_n && sel_prev_n_q;
	assign wp_fall = !sync_q[0] && wp_prev_n_q;

	// ****************************************
	// Power-up arming and transfer phase
	// ****************************************
	logic armed_q;
	phase_e phase_q;
	logic [2:0] bit_q;
	logic [7:0] shreg_q;
	logic body_first_q;
	logic byte_done;
	assign byte_done = sck_rise && bit_q == '0;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			armed_q <= 1'b0;
		end else if (clk_en && sel_fall) begin
			armed_q <= 1'b1;
		end
	end

	// Bits are counted only on serial clock edges, so a stalled clock holds position.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase_q <= PH_IDLE;
			bit_q <= BIT_MSB;
			shreg_q <= '0;
			body_first_q <= 1'b0;
		end else if (clk_en) begin
			if (sel_n) begin
				phase_q <= PH_IDLE;
				bit_q <= BIT_MSB;
			end else if (sel_fall) begin
				phase_q <= PH_INSTR;
				bit_q <= BIT_MSB;
				body_first_q <= 1'b1;
			end else if (sck_rise && phase_q != PH_IDLE) begin
				shreg_q <= {shreg_q[6:0], sync_q[1]};
				bit_q <= bit_q - 3'h1;
				if (byte_done) begin
					bit_q <= BIT_MSB;
					if (phase_q == PH_INSTR) begin
						phase_q <= PH_BODY;
					end else begin
						body_first_q <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			instr_q <= '0;
			instr_valid <= 1'b0;
		end else if (clk_en) begin
			instr_valid <= 1'b0;
			if (byte_done && phase_q == PH_INSTR && !sel_n) begin
				instr_q <= {shreg_q[6:0], sync_q[1]};
				instr_valid <= 1'b1;
			end
		end
	end

	// ****************************************
	// Two-entry receive buffer
	// ****************************************
	rx_word_s buf_q [2];
	logic [1:0] cnt_q;
	logic rd_ptr_q;
	logic wr_ptr_q;
	logic push;
	logic pop;
	logic [1:0] cnt_d;
	logic bypass;
	assign push = byte_done && phase_q == PH_BODY && !sel_n && cnt_q != 2'h2;
	assign pop = rx_valid && rx_ready;
	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	// An arriving byte goes straight to the output register when nothing older waits.
	assign bypass = push && (cnt_q == 2'h0 || (pop && cnt_q == 2'h1));

	// A full buffer drops further body bytes; the master must pace the clock to rx_ready.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_q <= '0;
			rd_ptr_q <= 1'b0;
			wr_ptr_q <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= '0;
			rx_first <= 1'b0;
		end else if (clk_en) begin
			if (push) begin
				buf_q[wr_ptr_q] <= '{data: {shreg_q[6:0], sync_q[1]}, first: body_first_q};
				wr_ptr_q <= !wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= !rd_ptr_q;
			end
			cnt_q <= cnt_d;
			rx_valid <= cnt_d != 2'h0;
			if (pop || !rx_valid) begin
				rx_data <= bypass ? {shreg_q[6:0], sync_q[1]} : buf_q[!rd_ptr_q].data;
				rx_first <= bypass ? body_first_q : buf_q[!rd_ptr_q].first;
			end
		end
	end

	// ****************************************
	// Serial output
	// ****************************************
	logic [7:0] tx_hold_q;
	logic tx_full_q;
	logic [7:0] txsh_q;
	logic tx_take;
	logic tx_shift;
	assign tx_take = tx_valid && tx_ready;
	assign tx_shift = sck_fall && !sel_n && phase_q == PH_BODY;
	// The held byte moves to the shifter at the fall that opens a byte, so its MSB is on
	// the line before the master's first rising edge of that byte.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
			tx_hold_q <= '0;
			tx_full_q <= 1'b0;
			txsh_q <= '0;
			tx_ready <= 1'b0;
		end else if (clk_en) begin
			serial_out_oe <= !sel_n && armed_q;
			tx_ready <= !sel_n && phase_q == PH_BODY && !tx_full_q && !tx_take;
			if (tx_shift && bit_q == BIT_MSB) begin
				serial_out <= tx_hold_q[BIT_MSB];
				txsh_q <= {tx_hold_q[6:0], 1'b0};
			end else if (tx_shift) begin
				serial_out <= txsh_q[BIT_MSB];
				txsh_q <= {txsh_q[6:0], 1'b0};
			end
			if (sel_n) begin
				tx_full_q <= 1'b0;
			end else if (tx_take) begin
				tx_hold_q <= tx_data;
				tx_full_q <= 1'b1;
			end else if (tx_shift && bit_q == BIT_MSB) begin
				tx_full_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Nonvolatile write gating
	// ****************************************
	logic wr_pending_q;
	logic [$clog2(NV_CYCLES+1)-1:0] nv_cnt_q;
	logic is_write_op;
	logic nv_start;
	assign is_write_op = (instr_q & OP_MASK) == OP_WRITE || instr_q == OP_WRSR;
	assign nv_start = !nv_write_busy && sel_n && wr_pending_q && sync_q[0];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wr_pending_q <= 1'b0;
			nv_write_busy <= 1'b0;
			nv_cnt_q <= '0;
			standby <= 1'b1;
		end else if (clk_en) begin
			// Standby is withheld in the very cycle the write starts, not one cycle late.
			standby <= sel_n && !nv_write_busy && !nv_start;
			if (instr_valid && is_write_op && sync_q[0]) begin
				wr_pending_q <= 1'b1;
			end else if (!sel_n && wp_fall) begin
				wr_pending_q <= 1'b0;
			end else if (sel_n) begin
				wr_pending_q <= 1'b0;
			end
			if (nv_write_busy) begin
				nv_cnt_q <= nv_cnt_q - 1'b1;
				if (nv_cnt_q == 1) begin
					nv_write_busy <= 1'b0;
				end
			end else if (nv_start) begin
				nv_write_busy <= 1'b1;
				nv_cnt_q <= ($clog2(NV_CYCLES+1))'(NV_CYCLES);
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_HIZ_DESELECT: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && sel_n |=> !serial_out_oe) else $error("output driven while deselected");
	AST_NO_OP_UNARMED: assert property (@(posedge ref_clk) disable iff (srst)
		!armed_q |-> !instr_valid) else $error("instruction before select edge");
	AST_ABORT_WP: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && !sel_n && wp_fall && !instr_valid |=> !wr_pending_q)
		else $error("write not aborted");
	AST_NV_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
		nv_write_busy && nv_cnt_q > 1 && clk_en |=> nv_write_busy)
		else $error("nv cycle ended early");
	AST_STANDBY: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && nv_write_busy |=> !standby) else $error("standby during nv write");
	AST_DESEL_RESET: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && sel_n |=> phase_q == PH_IDLE && bit_q == BIT_MSB)
		else $error("partial byte kept");
	AST_STALL: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && !sck_rise && !sel_n && !sel_fall |=> $stable(bit_q))
		else $error("bit moved without clock");
	AST_WP_BLOCK: assert property (@(posedge ref_clk) disable iff (srst)
		!nv_write_busy && !sync_q[0] |=> !nv_write_busy)
		else $error("write began while protected");
	AST_START_STANDBY: assert property (@(posedge ref_clk) disable iff (srst)
		clk_en && nv_start |=> nv_write_busy && !standby)
		else $error("standby at nv write start");
endmodule // spi_eeprom_pin_interface
`default_nettype wire

// >>> spi_pin_pkg.sv
`default_nettype none
package spi_pin_pkg;
	localparam int BYTE_W = 8;
	localparam logic [2:0] BIT_MSB = 3'h7;
	localparam logic [7:0] OP_MASK = 8'hF7;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int NV_WRITE_TIME_NS = 5000;
	localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_INSTR = 2'h1,
		PH_BODY = 2'h3
	} phase_e;

	typedef struct packed {
		logic [7:0] data;
		logic first;
	} rx_word_s;
endpackage
`default_nettype wire

// >>> spi_master_model.sv
`default_nettype none
module spi_master_model (
	output logic sel_n,
	output logic sclk,
	output logic mosi,
	output logic wp_n,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sel_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
		wp_n = 1'b1;
	end
	// The serial clock only runs inside frames and rests low between them.
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		for (int i = 7; i > 7 - nb; i--) begin
			mosi = tx[i];
			#32;
			rx[i] = miso;
			sclk = 1'b1;
			#32;
			sclk = 1'b0;
		end
	endtask
	task automatic open_frame();
		sel_n = 1'b0;
		#64;
	endtask
	// Select stays low to the last bit; the data line is then left changing.
	task automatic close_frame();
		#64;
		sel_n = 1'b1;
		mosi = ~mosi;
	endtask
endmodule // spi_master_model
`default_nettype wire

// >>> spi_eeprom_pin_interface_bench.sv
`default_nettype none
module spi_eeprom_pin_interface_bench
	import spi_pin_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NV = 10;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic rx_ready = 1'b1;
	logic sel_n, sclk, mosi, wp_n, so, so_oe, stby, busy, iv, rxv, rxf, sb;
	logic [7:0] iq, rxd, rb;
	logic miso_line, txr;
	logic [8:0] rxq[$];
	int n_mismatch = 0;
	int check_count = 0;
	int n_instr = 0;
	int cyc = 0;
	int n;
	always #2.5 ref_clk = ~ref_clk;
	// An undriven output line shows the opposite of the last bit, so a stale read shows up.
	assign miso_line = so_oe ? so : ~so;
	spi_master_model master (.sel_n(sel_n), .sclk(sclk), .mosi(mosi), .wp_n(wp_n),
		.miso(miso_line));
	spi_eeprom_pin_interface #(.NV_CYCLES(NV)) dut (.ref_clk(ref_clk), .srst(srst),
		.clk_en(1'b1), .select_watchdog_in_n(sel_n), .serial_clk(sclk), .serial_in(mosi),
		.write_protect_n(wp_n), .serial_out(so), .serial_out_oe(so_oe), .standby(stby),
		.nv_write_busy(busy), .instr_valid(iv), .instr_q(iq), .rx_valid(rxv),
		.rx_data(rxd), .rx_first(rxf), .rx_ready(rx_ready), .tx_data(8'hC5),
		.tx_ready(txr), .tx_valid(1'b1));
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (iv === 1'b1) n_instr <= n_instr + 1;
		if (rxv === 1'b1 && rx_ready === 1'b1) rxq.push_back({rxf, rxd});
		if (cyc == 30000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic send3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		rxq.delete();
		master.open_frame();
		master.xfer(a, 8, rb);
		master.xfer(b, 8, rb);
		master.xfer(c, 8, rb);
		master.close_frame();
	endtask
	// Counts busy cycles after deselect; may pull protect low once busy is seen.
	task automatic nvcount(input logic drop);
		n = 0;
		sb = 1'b0;
		repeat (40) @(negedge ref_clk) begin
			if (busy === 1'b1 && drop) master.wp_n = 1'b0;
			if (busy === 1'b1) n++;
			if (busy === 1'b1 && stby !== 1'b0) sb = 1'b1;
		end
		chk("stby_busy", 9'h0, {8'h0, sb});
		chk("stby_idle", 9'h1, {8'h0, stby});
		chk("oe_idle", 9'h0, {8'h0, so_oe});
		chk("tx_ready_idle", 9'h0, {8'h0, txr});
		master.wp_n = 1'b1;
	endtask
	task automatic t_unarmed();
		master.xfer(OP_WRITE, 8, rb);
		repeat (10) @(negedge ref_clk);
		chk("instr_count", 9'h0, 9'(n_instr));
		chk("oe_unarmed", 9'h0, {8'h0, so_oe});
		master.sel_n = 1'b1;
		#300;
	endtask
	task automatic t_write();
		send3(OP_WRITE, 8'h5A, 8'hC3);
		chk("instr", {1'b0, OP_WRITE}, {1'b0, iq});
		chk("rx_count", 9'h2, 9'(rxq.size()));
		chk("rx0", 9'h15A, rxq[0]);
		chk("rx1", 9'h0C3, rxq[1]);
		nvcount(1'b0);
		chk("nv_cycles", 9'(NV), 9'(n));
	endtask
	task automatic t_protect();
		master.wp_n = 1'b0;
		rx_ready = 1'b0;
		rxq.delete();
		master.open_frame();
		master.xfer(OP_WRITE, 8, rb);
		master.xfer(8'h11, 8, rb);
		master.xfer(8'h22, 8, rb);
		master.xfer(8'h33, 8, rb);
		master.close_frame();
		@(negedge ref_clk);
		rx_ready = 1'b1;
		nvcount(1'b0);
		chk("nv_protected", 9'h0, 9'(n));
		chk("rx_full", 9'h2, 9'(rxq.size()));
		chk("rx_kept0", 9'h111, rxq[0]);
		chk("rx_kept1", 9'h022, rxq[1]);
		master.wp_n = 1'b0;
		send3(OP_READ, 8'h10, 8'h00);
		chk("read_byte", 9'h0C5, {1'b0, rb});
		master.wp_n = 1'b1;
	endtask
	task automatic t_abort();
		master.open_frame();
		master.xfer(OP_WRITE, 8, rb);
		master.xfer(8'h44, 8, rb);
		master.wp_n = 1'b0;
		master.xfer(8'h55, 8, rb);
		// Protect is high again at deselect, so only the abort can stop this write.
		master.wp_n = 1'b1;
		master.close_frame();
		#50;
		nvcount(1'b0);
		chk("nv_aborted", 9'h0, 9'(n));
		send3(OP_WRITE, 8'h01, 8'h02);
		nvcount(1'b1);
		chk("nv_completes", 9'(NV), 9'(n));
	endtask
	task automatic t_partial();
		master.open_frame();
		master.xfer(8'hFF, 4, rb);
		master.close_frame();
		#300;
		rxq.delete();
		master.open_frame();
		master.xfer(OP_WRSR, 4, rb);
		#500;
		master.xfer(OP_WRSR << 4, 4, rb);
		master.xfer(8'h5A, 8, rb);
		master.close_frame();
		chk("instr_after_cut", {1'b0, OP_WRSR}, {1'b0, iq});
		chk("rx_after_stall", 9'h15A, rxq[0]);
		nvcount(1'b0);
		chk("nv_status", 9'(NV), 9'(n));
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#1;
		master.sel_n = 1'b0;
		repeat (5) @(negedge ref_clk);
		srst = 1'b0;
		chk("stby_reset", 9'h1, {8'h0, stby});
		t_unarmed();
		t_write();
		t_protect();
		t_abort();
		t_partial();
		final_report();
	end
endmodule // spi_eeprom_pin_interface_bench
`default_nettype wire
